// ==== isr_defines.vh ====
// named constants of the two-wire slave register port
// assumed: included by bare name from each design file
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH

// fixed upper nibble of the seven-bit device address
`define ISR_DEV_HI      4'h4
// bit count of one serial word and index of its last bit
`define ISR_WORD_BITS   4'h8
`define ISR_LAST_BIT    4'h7
`define ISR_CNT_ZERO    4'h0
`define ISR_CNT_ONE     4'h1
// register space: sixteen bytes, upper pointer nibble must be zero
`define ISR_PTR_HI_OK   4'h0
`define ISR_PTR_RST     8'h00
`define ISR_PTR_ONE     8'h01
`define ISR_BYTE_ZERO   8'h00
`define ISR_STRAP_RST   3'h0
`define ISR_REG_AW      4
`define ISR_REG_DEPTH   16

`endif

// ==== isr_host_model.sv ====
// host master model: drives the serial clock and the data line
// assumes: bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module isr_host_model (
   // clock
   input  wire logic i_clk,
   // bus pins
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   // bus idle, both lines released
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end
   // half a serial clock period
   task automatic hp();
      repeat (10) @(negedge i_clk);
   endtask
   // one slot: data set in low phase, sampled late in high phase
   task automatic slot(input logic drv, output logic smp);
      repeat (3) @(negedge i_clk);
      o_sda_oe = drv;
      hp();
      o_scl = 1'b1;
      hp();
      smp   = i_sda;
      o_scl = 1'b0;
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      repeat (3) @(negedge i_clk);
      o_sda_oe = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_oe = 1'b1;
      hp();
      o_scl = 1'b0;
   endtask
   // stop: data rises while clock high
   task automatic stop();
      repeat (3) @(negedge i_clk);
      o_sda_oe = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_oe = 1'b0;
      hp();
   endtask
   // send a word msb first, then sample the acknowledge slot
   task automatic wbyte(input logic [7:0] b, output logic [7:0] ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         slot(~b[i], s);
      slot(1'b0, s);
      ack = {7'h00, ~s};
   endtask
   // read a word msb first, then acknowledge or not
   task automatic rbyte(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         slot(1'b0, s);
         b = {b[6:0], s};
      end
      slot(mack, s);
   endtask
endmodule

// ==== isr_port.v ====
// two-wire serial slave port giving a host master byte access to
// sixteen single-byte registers
// assumed: serial clock and data arrive from pins and are synchronised
// here; I_ADR_STRAP is the measured strap code, stable at start-up;
// the data pin is open drain, pulled up outside
`timescale 1ns/1ps
`include "isr_defines.vh"

module isr_port (
   // clock and reset
   input  wire       I_CLK,
   input  wire       I_NRST,
   // serial bus pins
   input  wire       I_SCL,
   input  wire       I_SDA,
   output wire       O_SDA,
   output wire       O_SDA_OE,
   // configuration
   input  wire [2:0] I_ADR_STRAP,
   input  wire       I_SW_MODE,
   // register write notice to the device
   output reg        O_WR_STB,
   output reg  [3:0] O_WR_ADDR,
   output reg  [7:0] O_WR_DATA,
   // register read notice to the device
   output reg        O_RD_STB,
   output reg  [3:0] O_RD_ADDR
);

   // one-hot states
   localparam [9:0] ST_IDLE = 10'h001;
   localparam [9:0] ST_ADDR = 10'h002;
   localparam [9:0] ST_AACK = 10'h004;
   localparam [9:0] ST_REG  = 10'h008;
   localparam [9:0] ST_RACK = 10'h010;
   localparam [9:0] ST_WDAT = 10'h020;
   localparam [9:0] ST_WACK = 10'h040;
   localparam [9:0] ST_TX   = 10'h080;
   localparam [9:0] ST_MACK = 10'h100;
   localparam [9:0] ST_SKIP = 10'h200;

   reg  [2:0] scl_q;
   reg  [2:0] sda_q;
   reg  [1:0] mode_q;
   reg  [2:0] strap_q;
   reg        strap_done_q;
   reg  [9:0] state_q;
   reg  [3:0] cnt_q;
   reg  [7:0] shift_q;
   reg  [7:0] tx_q;
   reg  [7:0] ptr_q;
   reg        rw_q;
   reg        oe_q;
   reg        nack_q;
   reg        mem_we_q;
   wire [7:0] rd_data;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;
   wire       addr_match;
   wire       ptr_valid;
   wire [7:0] ptr_inc;

   // pin synchronisers; stage zero feeds only stage one
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         scl_q  <= 3'h7;
         sda_q  <= 3'h7;
         mode_q <= 2'h0;
      end else begin
         scl_q  <= {scl_q[1:0], I_SCL};
         sda_q  <= {sda_q[1:0], I_SDA};
         mode_q <= {mode_q[0], I_SW_MODE};
      end
   end

   // bus events from synchronised stages one and two
   assign scl_rise  = scl_q[1] & ~scl_q[2];
   assign scl_fall  = ~scl_q[1] & scl_q[2];
   assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

   // address compare: fixed nibble plus strap bits, direction excluded
   assign addr_match = (shift_q[7:4] == `ISR_DEV_HI) &&
                       (shift_q[3:1] == strap_q);
   assign ptr_valid  = (ptr_q[7:4] == `ISR_PTR_HI_OK);
   assign ptr_inc    = ptr_q + `ISR_PTR_ONE;

   // strap code caught once after reset release
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         strap_q      <= `ISR_STRAP_RST;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_q      <= I_ADR_STRAP;
         strap_done_q <= 1'b1;
      end
   end

   // open drain: only ever pull low
   assign O_SDA    = 1'b0;
   assign O_SDA_OE = oe_q;

   // register store
   isr_regmem u_mem (
      .i_clk     (I_CLK),
      .i_nrst    (I_NRST),
      .i_wr_en   (mem_we_q),
      .i_wr_addr (O_WR_ADDR),
      .i_wr_data (O_WR_DATA),
      .i_rd_addr (ptr_q[3:0]),
      .o_rd_data (rd_data)
   );

   // protocol engine
   always @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_q   <= ST_IDLE;
         cnt_q     <= `ISR_CNT_ZERO;
         shift_q   <= `ISR_BYTE_ZERO;
         tx_q      <= `ISR_BYTE_ZERO;
         ptr_q     <= `ISR_PTR_RST;
         rw_q      <= 1'b0;
         oe_q      <= 1'b0;
         nack_q    <= 1'b0;
         mem_we_q  <= 1'b0;
         O_WR_STB  <= 1'b0;
         O_WR_ADDR <= 4'h0;
         O_WR_DATA <= `ISR_BYTE_ZERO;
         O_RD_STB  <= 1'b0;
         O_RD_ADDR <= 4'h0;
      end else begin
         mem_we_q <= 1'b0;
         O_WR_STB <= 1'b0;
         O_RD_STB <= 1'b0;
         if (!mode_q[1] || !strap_done_q) begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
         end else if (stop_det) begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
         end else if (start_det) begin
            state_q <= ST_ADDR;
            cnt_q   <= `ISR_CNT_ZERO;
            oe_q    <= 1'b0;
         end else begin
            case (state_q)
               // receive a word, msb first
               ST_ADDR, ST_REG, ST_WDAT: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_q[1]};
                     cnt_q   <= cnt_q + `ISR_CNT_ONE;
                  end else if (scl_fall && cnt_q == `ISR_WORD_BITS) begin
                     cnt_q <= `ISR_CNT_ZERO;
                     if (state_q == ST_ADDR) begin
                        rw_q <= shift_q[0];
                        if (addr_match) begin
                           state_q <= ST_AACK;
                           oe_q    <= 1'b1;
                        end else begin
                           state_q <= ST_SKIP;
                        end
                     end else if (state_q == ST_REG) begin
                        ptr_q   <= shift_q;
                        state_q <= ST_RACK;
                        oe_q    <= 1'b1;
                     end else begin
                        state_q <= ST_WACK;
                        oe_q    <= 1'b1;
                        if (ptr_valid) begin
                           mem_we_q  <= 1'b1;
                           O_WR_STB  <= 1'b1;
                           O_WR_ADDR <= ptr_q[3:0];
                           O_WR_DATA <= shift_q;
                        end
                     end
                  end
               end
               // address acknowledge ends on the falling clock
               ST_AACK: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        state_q   <= ST_TX;
                        tx_q      <= ptr_valid ? rd_data :
                                     `ISR_BYTE_ZERO;
                        // out of range sends zeros, so bit 7 pulls low
                        oe_q      <= ~(ptr_valid & rd_data[7]);
                        O_RD_STB  <= ptr_valid;
                        O_RD_ADDR <= ptr_q[3:0];
                     end else begin
                        state_q <= ST_REG;
                        oe_q    <= 1'b0;
                     end
                  end
               end
               // register word acknowledge
               ST_RACK: begin
                  if (scl_fall) begin
                     state_q <= ST_WDAT;
                     oe_q    <= 1'b0;
                  end
               end
               // write byte acknowledge, then advance pointer
               ST_WACK: begin
                  if (scl_fall) begin
                     state_q <= ST_WDAT;
                     oe_q    <= 1'b0;
                     ptr_q   <= ptr_inc;
                  end
               end
               // send byte msb first, shifting on the falling clock
               ST_TX: begin
                  if (scl_fall) begin
                     if (cnt_q == `ISR_LAST_BIT) begin
                        state_q <= ST_MACK;
                        oe_q    <= 1'b0;
                        cnt_q   <= `ISR_CNT_ZERO;
                     end else begin
                        tx_q  <= {tx_q[6:0], 1'b0};
                        oe_q  <= ~tx_q[6];
                        cnt_q <= cnt_q + `ISR_CNT_ONE;
                     end
                  end
               end
               // master acknowledge slot of a read byte; the pointer
               // moves on the rise so the store holds the next byte
               // well before the fall that launches its first bit
               ST_MACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_q[1];
                     ptr_q  <= ptr_inc;
                  end else if (scl_fall) begin
                     if (nack_q) begin
                        state_q <= ST_SKIP;
                     end else begin
                        state_q <= ST_TX;
                        tx_q    <= ptr_valid ? rd_data : `ISR_BYTE_ZERO;
                        oe_q    <= ~(ptr_valid & rd_data[7]);
                     end
                  end
               end
               // released bus, wait for start or stop
               ST_SKIP: begin
                  oe_q <= 1'b0;
               end
               ST_IDLE: begin
                  oe_q <= 1'b0;
               end
               default: begin
                  state_q <= ST_IDLE;
                  oe_q    <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// ==== isr_port_properties.sv ====
// timing checks on the serial slave port, bound to the port
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ps
module isr_port_chk (
   // clock and reset
   input wire logic       I_CLK,
   input wire logic       I_NRST,
   // watched ports
   input wire logic       I_SCL,
   input wire logic       O_SDA,
   input wire logic       O_SDA_OE,
   input wire logic       I_SW_MODE,
   input wire logic       O_WR_STB,
   input wire logic [3:0] O_WR_ADDR,
   input wire logic [7:0] O_WR_DATA,
   input wire logic       O_RD_STB
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);
   // software mode held off for a while
   sequence s_sw_off;
      !I_SW_MODE [*4];
   endsequence
   // clock low for the synchroniser depth
   sequence s_scl_low;
      !I_SCL && !$past(I_SCL, 3);
   endsequence
   chk_sda_value_low: assert property (O_SDA == 1'b0)
      else $error("data value not low");
   chk_oe_in_low: assert property ($changed(O_SDA_OE) |-> s_scl_low)
      else $error("drive changed outside clock low");
   chk_ack_stands: assert property (I_SCL && $past(I_SCL, 4)
      |-> $stable(O_SDA_OE)) else $error("drive changed in clock high");
   chk_wr_pulse: assert property (O_WR_STB |=> !O_WR_STB)
      else $error("write strobe too long");
   chk_wr_acked: assert property (O_WR_STB |-> ##[0:4] O_SDA_OE)
      else $error("written byte not acknowledged");
   chk_rd_pulse: assert property (O_RD_STB |=> !O_RD_STB)
      else $error("read strobe too long");
   chk_wr_hold: assert property (!O_WR_STB |-> $stable(O_WR_ADDR)
      && $stable(O_WR_DATA)) else $error("write notice moved");
   chk_sw_quiet: assert property (s_sw_off |-> !O_SDA_OE
      && !O_WR_STB && !O_RD_STB) else $error("active outside sw mode");
endmodule
bind isr_port isr_port_chk u_chk (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_SCL(I_SCL), .O_SDA(O_SDA),
   .O_SDA_OE(O_SDA_OE), .I_SW_MODE(I_SW_MODE), .O_WR_STB(O_WR_STB),
   .O_WR_ADDR(O_WR_ADDR), .O_WR_DATA(O_WR_DATA), .O_RD_STB(O_RD_STB)
);

// ==== isr_regmem.v ====
// sixteen single-byte register store, one write and one read port
// assumed: write and read ports on the same clock, no reset on contents
`timescale 1ns/1ps
`include "isr_defines.vh"

module isr_regmem (
   // clock and reset
   input  wire                      i_clk,
   input  wire                      i_nrst,
   // write port
   input  wire                      i_wr_en,
   input  wire [`ISR_REG_AW-1:0]    i_wr_addr,
   input  wire [7:0]                i_wr_data,
   // read port, data one cycle after address
   input  wire [`ISR_REG_AW-1:0]    i_rd_addr,
   output reg  [7:0]                o_rd_data
);

   reg [7:0] mem_q [0:`ISR_REG_DEPTH-1];

   // storage write
   always @(posedge i_clk) begin
      if (i_wr_en) begin
         mem_q[i_wr_addr] <= i_wr_data;
      end
   end

   // registered read data
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rd_data <= `ISR_BYTE_ZERO;
      end else begin
         o_rd_data <= mem_q[i_rd_addr];
      end
   end

endmodule

// ==== tb.sv ====
// bench of the serial slave port against the host master model
// assumes: model and port share one pulled-up data line
`timescale 1ns/1ps
module tb;
   // device address 0100 101 plus direction
   localparam logic [7:0] AW = 8'h4A;
   localparam logic [7:0] AR = 8'h4B;
   logic       clk   = 1'b0;
   logic       nrst  = 1'b0;
   logic       sw    = 1'b1;
   logic [2:0] strap = 3'h5;
   logic       scl, m_oe, sda, d_oe, wr_stb, rd_stb;
   logic [3:0] wr_a, rd_a, wa, ra;
   logic [7:0] wr_d, wd, a, d;
   logic [7:0] wr_n  = 8'h00;
   int         error_cnt = 0;
   int         total_checks = 0;
   int         cyc = 0;
   // open-drain data line with pull-up
   assign sda = ~(d_oe | m_oe);
   isr_port dut (
      .I_CLK(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA(sda), .O_SDA(),
      .O_SDA_OE(d_oe), .I_ADR_STRAP(strap), .I_SW_MODE(sw),
      .O_WR_STB(wr_stb), .O_WR_ADDR(wr_a), .O_WR_DATA(wr_d),
      .O_RD_STB(rd_stb), .O_RD_ADDR(rd_a)
   );
   isr_host_model mst (
      .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe)
   );
   // clock
   initial forever #10 clk = ~clk;
   // capture write and read notices
   always @(posedge clk) begin
      if (wr_stb === 1'b1) begin
         wr_n <= wr_n + 8'h01;
         wa   <= wr_a;
         wd   <= wr_d;
      end
      if (rd_stb === 1'b1)
         ra <= rd_a;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out();
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // send a word and judge its acknowledge
   task automatic wr(input logic [7:0] b, input logic [7:0] e);
      mst.wbyte(b, a);
      chk("ack", a, e);
   endtask
   // read a word and judge its value
   task automatic rd(input logic m, input logic [7:0] e);
      mst.rbyte(m, d);
      chk("rdata", d, e);
   endtask
   task automatic t_write();
      mst.start();
      wr(AW, 8'h01);
      wr(8'h03, 8'h01);
      wr(8'hA5, 8'h01);
      chk("wa", {4'h0, wa}, 8'h03);
      chk("wd", wd, 8'hA5);
      wr(8'h5A, 8'h01);
      chk("wa", {4'h0, wa}, 8'h04);
      chk("wn", wr_n, 8'h02);
      mst.stop();
   endtask
   task automatic t_read();
      mst.start();
      wr(AW, 8'h01);
      wr(8'h03, 8'h01);
      mst.start();
      wr(AR, 8'h01);
      rd(1'b1, 8'hA5);
      chk("ra", {4'h0, ra}, 8'h03);
      rd(1'b0, 8'h5A);
      mst.stop();
   endtask
   task automatic t_miss();
      mst.start();
      wr(AW, 8'h01);
      wr(8'h03, 8'h01);
      mst.start();
      wr(8'h44, 8'h00);
      wr(8'h07, 8'h00);
      mst.start();
      wr(8'h5A, 8'h00);
      mst.start();
      wr(AR, 8'h01);
      rd(1'b0, 8'hA5);
      mst.stop();
      chk("wn", wr_n, 8'h02);
   endtask
   task automatic t_range();
      mst.start();
      wr(AW, 8'h01);
      wr(8'h10, 8'h01);
      wr(8'h33, 8'h01);
      chk("wn", wr_n, 8'h02);
      mst.start();
      wr(AR, 8'h01);
      rd(1'b0, 8'h00);
      mst.stop();
   endtask
   task automatic t_swoff();
      sw = 1'b0;
      mst.start();
      wr(AW, 8'h00);
      mst.stop();
      sw = 1'b1;
   endtask
   // reset, strap moved after start-up, then the scenarios
   initial begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      strap = 3'h2;
      t_write();
      t_read();
      t_miss();
      t_range();
      t_swoff();
      close_out();
   end
endmodule
